// >>> src/qcc_top.sv
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module qcc_top
	import qcc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog comparator cores
	input wire logic [3:0] cmp_raw,
	input wire logic [3:0] amp_clk_phase,
	output logic [3:0] cmp_enable,
	output logic [11:0] neg_select,
	output logic [3:0] pos_from_amp,
	output logic [3:0] cmp_use_amp_clk,
	output logic pll_clock_choice,
	output logic [1:0] reference_select_field,
	// interrupt controller
	input wire logic [3:0] vector_ack,
	output logic [3:0] irq_req,
	// conversion triggers
	output logic [3:0] conv_trigger,
	// timer capture front end
	input wire logic timer_capture_edge_select,
	input wire logic timer_capture_irq_enable,
	output logic capture_level,
	output logic capture_event,
	output logic capture_irq_req
);
	// registers and wires
	logic [7:0] ctrl_ff [NUM_UNITS];
	logic [7:0] misc_ff;
	logic halve_ff;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;
	logic [3:0] irq_ff, trig_ff, en_ff, amp_ff, ampclk_ff;
	logic [11:0] neg_ff;
	logic pll_ff, cap_lvl_ff, cap_evt_ff, cap_irq_ff;
	logic [1:0] refs_ff;
	logic [3:0] out_lvl, flag, rise, fall, tick, sw_clr;
	logic [3:0] amp_s1_ff, amp_s2_ff, amp_s3_ff;
	logic setup, wr_acc, rd_acc, addr_ok, status_wr;
	logic [31:0] rd_mux;
	logic cap_hit, nxt_halve;

	// true for any of the four control offsets
	function automatic logic is_ctrl(input logic [7:0] a);
		return a == ADDR_CTRL0 || a == ADDR_CTRL1 ||
			a == ADDR_CTRL2 || a == ADDR_CTRL3;
	endfunction

	////////////////////////////////////////////////////////////////////
	// apb decode: zero wait state, unmapped gives pslverr
	assign setup = psel && !penable;
	assign addr_ok = is_ctrl(paddr) || paddr == ADDR_STATUS ||
		paddr == ADDR_MISC;
	assign wr_acc = psel && penable && pready_ff && pwrite && addr_ok;
	assign rd_acc = setup && !pwrite;
	assign status_wr = wr_acc && paddr == ADDR_STATUS;
	// write one to a flag clears it
	assign sw_clr = status_wr ? pwdata[BIT_FLAG_LO +: NUM_UNITS] : 4'h0;
	assign rd_mux = (paddr == ADDR_CTRL0) ? {24'h0, ctrl_ff[0]} :
		(paddr == ADDR_CTRL1) ? {24'h0, ctrl_ff[1]} :
		(paddr == ADDR_CTRL2) ? {24'h0, ctrl_ff[2]} :
		(paddr == ADDR_CTRL3) ? {24'h0, ctrl_ff[3]} :
		(paddr == ADDR_STATUS) ? {24'h0, flag, out_lvl} :
		(paddr == ADDR_MISC) ? {24'h0, misc_ff} : 32'h0;

	// pready rises in the access phase, one cycle after setup
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup && !addr_ok;
			// writes and misses answer zero, so stale data never shows
			if (setup) begin
				prdata_ff <= rd_acc ? rd_mux : 32'h0;
			end
		end
	end

	// control registers; bit 3 of units 2 and 3 is reserved and reads zero
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				ctrl_ff[i] <= CTRL_RESET;
			end
			misc_ff <= MISC_RESET;
		end else if (wr_acc) begin
			if (paddr == ADDR_CTRL0) begin
				ctrl_ff[0] <= pwdata[7:0];
			end
			if (paddr == ADDR_CTRL1) begin
				ctrl_ff[1] <= pwdata[7:0];
			end
			if (paddr == ADDR_CTRL2) begin
				ctrl_ff[2] <= pwdata[7:0] & CTRL2_MASK;
			end
			if (paddr == ADDR_CTRL3) begin
				ctrl_ff[3] <= pwdata[7:0] & CTRL2_MASK;
			end
			if (paddr == ADDR_MISC) begin
				misc_ff <= pwdata[7:0] & MISC_MASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// sample timing: io clock, or half rate under halving
	assign nxt_halve = misc_ff[BIT_HALVE] ? ~halve_ff : 1'b1;
	genvar g;
	generate
		for (g = 0; g < NUM_UNITS; g++) begin : gen_unit
			// amp-routed units sample on a rise of their synced amp clock
			assign tick[g] = (misc_ff[BIT_AMP_LO + (g % 3)] && g < 3) ?
				(amp_s2_ff[g] && !amp_s3_ff[g]) :
				halve_ff;
			qcc_unit u_unit (
				.mclk(mclk),
				.nrst(nrst),
				.raw_cmp(cmp_raw[g]),
				.sample_tick(tick[g]),
				.enable(ctrl_ff[g][BIT_EN]),
				.irq_en(ctrl_ff[g][BIT_IE]),
				.edge_sel(qcc_is_t'(ctrl_ff[g][BIT_IS_HI:BIT_IS_LO])),
				.vector_ack(vector_ack[g]),
				.sw_clear(sw_clr[g]),
				.out_level(out_lvl[g]),
				.flag(flag[g]),
				.rise_evt(rise[g]),
				.fall_evt(fall[g])
			);
		end
	endgenerate

	// capture routing: only when route bit is set
	assign cap_hit = ctrl_ff[1][BIT_AUX] &&
		(timer_capture_edge_select ? rise[1] : fall[1]);

	////////////////////////////////////////////////////////////////////
	// registered outputs toward analog, irq and timer
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			halve_ff <= 1'b1;
			amp_s1_ff <= 4'h0;
			amp_s2_ff <= 4'h0;
			amp_s3_ff <= 4'h0;
			irq_ff <= 4'h0;
			trig_ff <= 4'h0;
			en_ff <= 4'h0;
			neg_ff <= 12'h0;
			amp_ff <= 4'h0;
			ampclk_ff <= 4'h0;
			pll_ff <= 1'b0;
			refs_ff <= 2'h0;
			cap_lvl_ff <= 1'b0;
			cap_evt_ff <= 1'b0;
			cap_irq_ff <= 1'b0;
		end else begin
			halve_ff <= nxt_halve;
			amp_s1_ff <= amp_clk_phase;
			amp_s2_ff <= amp_s1_ff;
			// edge taken past the sync pair, never off the first flop
			amp_s3_ff <= amp_s2_ff;
			for (int i = 0; i < NUM_UNITS; i++) begin
				irq_ff[i] <= flag[i] & ctrl_ff[i][BIT_IE];
				en_ff[i] <= ctrl_ff[i][BIT_EN];
				neg_ff[3*i +: 3] <= ctrl_ff[i][BIT_M_HI:BIT_M_LO];
			end
			trig_ff <= flag;
			amp_ff <= {1'b0, misc_ff[BIT_AMP_LO +: 3]};
			ampclk_ff <= {1'b0, misc_ff[BIT_AMP_LO +: 3]};
			pll_ff <= ctrl_ff[0][BIT_AUX];
			refs_ff <= misc_ff[BIT_REFS_LO +: 2];
			// no level reaches the timer while unrouted
			cap_lvl_ff <= ctrl_ff[1][BIT_AUX] & out_lvl[1];
			cap_evt_ff <= cap_hit;
			cap_irq_ff <= cap_hit & timer_capture_irq_enable;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq_req = irq_ff;
	assign conv_trigger = trig_ff;
	assign cmp_enable = en_ff;
	assign neg_select = neg_ff;
	assign pos_from_amp = amp_ff;
	assign cmp_use_amp_clk = ampclk_ff;
	assign pll_clock_choice = pll_ff;
	assign reference_select_field = refs_ff;
	assign capture_level = cap_lvl_ff;
	assign capture_event = cap_evt_ff;
	assign capture_irq_req = cap_irq_ff;
endmodule
`default_nettype wire

// >>> src/qcc_pkg.sv
package qcc_pkg;
	// register byte addresses on the apb bus
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_CTRL1 = 8'h04;
	localparam logic [7:0] ADDR_CTRL2 = 8'h08;
	localparam logic [7:0] ADDR_CTRL3 = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_MISC = 8'h14;
	// control register fields
	localparam int BIT_EN = 7;
	localparam int BIT_IE = 6;
	localparam int BIT_IS_HI = 5;
	localparam int BIT_IS_LO = 4;
	localparam int BIT_AUX = 3;
	localparam int BIT_M_HI = 2;
	localparam int BIT_M_LO = 0;
	// status register fields
	localparam int BIT_FLAG_LO = 4;
	localparam int BIT_OUT_LO = 0;
	// misc register fields
	localparam int BIT_HALVE = 0;
	localparam int BIT_AMP_LO = 1;
	localparam int BIT_REFS_LO = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MISC_RESET = 8'h00;
	localparam logic [7:0] MISC_MASK = 8'h3F;
	localparam logic [7:0] CTRL2_MASK = 8'hF7;
	localparam int NUM_UNITS = 4;
	// interrupt edge select codes
	typedef enum logic [1:0] {
		QCC_IS_TOGGLE = 2'h0,
		QCC_IS_RSVD = 2'h1,
		QCC_IS_FALL = 2'h2,
		QCC_IS_RISE = 2'h3
	} qcc_is_t;
	// negative input select codes
	localparam logic [2:0] NEG_DIV640 = 3'h0;
	localparam logic [2:0] NEG_DIV320 = 3'h1;
	localparam logic [2:0] NEG_DIV213 = 3'h2;
	localparam logic [2:0] NEG_DIV160 = 3'h3;
	localparam logic [2:0] NEG_BANDGAP = 3'h4;
	localparam logic [2:0] NEG_DAC = 3'h5;
	localparam logic [2:0] NEG_PIN = 3'h6;
	localparam logic [2:0] NEG_RSVD = 3'h7;
endpackage

// >>> src/qcc_unit.sv
`timescale 1ns/1ps
`default_nettype none
// one comparator's digital side: sampling, edge events, flag
module qcc_unit
	import qcc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// analog side (asynchronous level)
	input wire logic raw_cmp,
	// controls
	input wire logic sample_tick,
	input wire logic enable,
	input wire logic irq_en,
	input wire qcc_pkg::qcc_is_t edge_sel,
	input wire logic vector_ack,
	input wire logic sw_clear,
	// results
	output logic out_level,
	output logic flag,
	output logic rise_evt,
	output logic fall_evt
);
	logic sync1_ff, sync2_ff, out_ff, flag_ff;
	logic nxt_out, nxt_flag, rise, fall, hit, clr;

	// new comparison only on sample tick of enabled unit
	assign nxt_out = (enable && sample_tick) ? sync2_ff : (enable & out_ff);
	assign rise = enable && sample_tick && sync2_ff && !out_ff;
	assign fall = enable && sample_tick && !sync2_ff && out_ff;
	// reserved select code raises nothing
	assign hit = (edge_sel == QCC_IS_TOGGLE) ? (rise | fall) :
		(edge_sel == QCC_IS_RISE) ? rise :
		(edge_sel == QCC_IS_FALL) ? fall : 1'b0;
	assign clr = sw_clear | (vector_ack & irq_en);
	// set wins over a same-cycle clear
	assign nxt_flag = hit | (flag_ff & ~clr);

	// two flops before the analog level is used
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			out_ff <= 1'b0;
			flag_ff <= 1'b0;
		end else begin
			sync1_ff <= raw_cmp;
			sync2_ff <= sync1_ff;
			out_ff <= nxt_out;
			flag_ff <= nxt_flag;
		end
	end

	assign out_level = out_ff;
	assign flag = flag_ff;
	assign rise_evt = rise;
	assign fall_evt = fall;
endmodule
`default_nettype wire

// >>> verif/qcc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// port relations of the comparator block, seen from outside
module qcc_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// unit side
	input wire logic [3:0] cmp_enable,
	input wire logic [3:0] pos_from_amp,
	input wire logic [3:0] cmp_use_amp_clk,
	input wire logic [3:0] irq_req,
	input wire logic [3:0] conv_trigger,
	input wire logic capture_event,
	input wire logic capture_irq_req
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	chk_ready_setup: assert property (pready |-> $past(psel && !penable))
		else $error("pready without setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error answer");
	chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	// irq and trigger leave the same flag stage together
	chk_irq_gate: assert property ((irq_req & ~conv_trigger) == 4'h0)
		else $error("irq without flag");
	chk_off_quiet: assert property ((conv_trigger & ~$past(conv_trigger)
		& ~(cmp_enable | $past(cmp_enable))) == 4'h0)
		else $error("flag set while disabled");
	chk_amp_pair: assert property (pos_from_amp == cmp_use_amp_clk
		&& !pos_from_amp[3])
		else $error("amp routing mismatch");
	chk_cap_pulse: assert property (capture_event |=> !capture_event)
		else $error("capture event too long");
	chk_cap_irq: assert property (capture_irq_req
		|-> capture_event || $past(capture_event))
		else $error("capture irq without event");
endmodule
bind qcc_top qcc_checker qcc_checker_i (.mclk, .nrst, .psel, .penable,
	.prdata, .pready, .pslverr, .cmp_enable, .pos_from_amp, .cmp_use_amp_clk,
	.irq_req, .conv_trigger, .capture_event, .capture_irq_req);
`default_nettype wire

// >>> verif/qcc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// four clocked analog cores; output follows the level the bench asks for
module qcc_analog_model (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// commanded levels
	input wire logic [3:0] lvl,
	// core outputs
	output logic [3:0] cmp_raw,
	output logic [3:0] amp_clk_phase
);
	// compare on falling edges; amp clock at half rate
	always_ff @(negedge mclk or negedge nrst) begin
		if (!nrst) begin
			cmp_raw <= 4'h0;
			amp_clk_phase <= 4'h0;
		end else begin
			cmp_raw <= lvl;
			amp_clk_phase <= ~amp_clk_phase;
		end
	end
endmodule
`default_nettype wire

// >>> verif/tb_qcc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_qcc_top;
	import qcc_pkg::*;
	logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic tcs = 0, tcie = 0, pready, pslverr, es;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] vector_ack = 4'h0, lvl = 4'h0, cmp_raw, amp_clk_phase;
	logic [3:0] cmp_enable, pos_from_amp, cmp_use_amp_clk, irq_req;
	logic [3:0] conv_trigger;
	logic [11:0] neg_select;
	logic [1:0] reference_select_field, c;
	logic pll_clock_choice, capture_level, capture_event, capture_irq_req;
	logic up, dn, ie;
	int err_total = 0, total_checks = 0, ncap = 0, nirq = 0;
	always #10 mclk = ~mclk;
	// count capture pulses
	always @(posedge mclk) begin
		ncap += int'(capture_event);
		nirq += int'(capture_irq_req);
	end
	qcc_top qcc_top_i (.mclk, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cmp_raw, .amp_clk_phase,
		.cmp_enable, .neg_select, .pos_from_amp, .cmp_use_amp_clk,
		.pll_clock_choice, .reference_select_field, .vector_ack, .irq_req,
		.conv_trigger, .timer_capture_edge_select(tcs),
		.timer_capture_irq_enable(tcie), .capture_level, .capture_event,
		.capture_irq_req);
	qcc_analog_model qcc_analog_model_i (.mclk, .nrst, .lvl, .cmp_raw,
		.amp_clk_phase);
	////////////////////////////////////////////////////////////////////////
	// one apb transfer; entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		es = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			err_total++;
			tally_and_finish();
		end
		@(posedge mclk);
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// hang guard at 50000 cycles, far above the test's run length
	initial begin
		#1000000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		for (int a = 0; a < 4; a++) begin
			apb(0, 8'(a * 4), 0);
			cmp(rd, 32'h0);
		end
		apb(1, ADDR_CTRL2, 32'hFF);
		apb(0, ADDR_CTRL2, 0);
		cmp(rd, {24'h0, CTRL2_MASK});
		apb(0, 8'h18, 0);
		cmp({es, rd[30:0]}, 32'h80000000);
		apb(1, ADDR_MISC, 32'h3E);
		@(posedge mclk);
		cmp({pos_from_amp, reference_select_field}, 32'h1F);
		cmp(cmp_use_amp_clk, 32'h7);
		apb(1, ADDR_MISC, 32'h01);
		// every edge code, rise then fall; halving keeps ticks sparse
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			ie = (i == 0);
			up = (c == QCC_IS_TOGGLE || c == QCC_IS_RISE);
			dn = (c == QCC_IS_TOGGLE || c == QCC_IS_FALL);
			apb(1, ADDR_CTRL0, {24'h0, 1'b1, ie, c, 1'b0, 3'(i + 4)});
			@(posedge mclk);
			cmp(neg_select[2:0], 32'(i + 4));
			lvl[0] <= 1'b1;
			repeat (8) @(posedge mclk);
			apb(0, ADDR_STATUS, 0);
			cmp(rd, {27'h0, up, 4'h1});
			cmp({irq_req[0], conv_trigger[0]}, {ie & up, up});
			apb(1, ADDR_STATUS, 32'hF0);
			lvl[0] <= 1'b0;
			repeat (8) @(posedge mclk);
			apb(0, ADDR_STATUS, 0);
			cmp(rd, {27'h0, dn, 4'h0});
			// ack clears only with the interrupt enabled
			vector_ack[0] <= 1'b1;
			@(posedge mclk);
			vector_ack[0] <= 1'b0;
			apb(0, ADDR_STATUS, 0);
			cmp(rd, {27'h0, dn & !ie, 4'h0});
			apb(1, ADDR_STATUS, {27'h0, !ie, 4'h0});
			apb(0, ADDR_STATUS, 0);
			cmp(rd, 32'h0);
		end
		apb(1, ADDR_CTRL0, 32'h48);
		@(posedge mclk);
		cmp({cmp_enable[0], pll_clock_choice}, 32'h1);
		lvl[0] <= 1'b1;
		repeat (8) @(posedge mclk);
		apb(0, ADDR_STATUS, 0);
		cmp(rd, 32'h0);
		apb(1, ADDR_CTRL1, 32'h80);
		lvl[1] <= 1'b1;
		repeat (8) @(posedge mclk);
		cmp({capture_level, ncap[3:0]}, 32'h0);
		lvl[1] <= 1'b0;
		repeat (8) @(posedge mclk);
		apb(1, ADDR_CTRL1, 32'h88);
		// edge select and irq enable swapped between the two halves
		for (int j = 0; j < 4; j++) begin
			tcs <= j[1];
			tcie <= !j[1];
			lvl[1] <= !j[0];
			repeat (8) @(posedge mclk);
			cmp(capture_level, !j[0]);
		end
		cmp({ncap[3:0], nirq[3:0]}, 32'h21);
		tally_and_finish();
	end
endmodule
`default_nettype wire
